/* File: shared/hdc_pkg.sv */
/*
  constants shared by the disk controller pin logic and its data fifo.
  assumes a 200 MHz system clock; the 5 MHz write clock is made from it.
*/
package hdc_pkg;
  // ==================================================
  // timing
  localparam int SYS_HZ = 200_000_000;
  localparam int WCLK_HZ = 5_000_000;
  // half-cell enable: two per write clock period
  localparam int HALF_DIV = SYS_HZ / (2 * WCLK_HZ);
  localparam logic [4:0] HALF_LAST = 5'(HALF_DIV - 1);
  // ==================================================
  // register file indexes and reset value
  localparam logic [2:0] TF_STEPS = 3'h1;
  localparam logic [2:0] TF_SIZE_HEAD = 3'h6;
  localparam logic [2:0] TF_CMD = 3'h7;
  localparam logic [7:0] TF_RESET = 8'h00;
  // size field of size_head_drive_reg
  localparam int SIZE_LSB = 5;
  localparam logic [10:0] SECT_MIN = 11'h080;
  // ==================================================
  // status bits
  localparam int ST_ERR = 0;
  localparam int ST_REQ = 3;
  localparam int ST_FAULT = 5;
  localparam int ST_RDY = 6;
  localparam int ST_BUSY = 7;
  // ==================================================
  // commands: opcode in the high nibble
  localparam logic [3:0] CMD_STEP = 4'h1;
  localparam logic [3:0] CMD_READ = 4'h2;
  localparam logic [3:0] CMD_WRITE = 4'h3;
  localparam int CMD_OPT_BIT = 3;
  localparam int CMD_DIR_BIT = 0;
  // ==================================================
  // data fifo
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;
endpackage

/* File: src/hdc_fifo.sv */
/*
  small synchronous fifo with valid/ready on both sides.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module hdc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // sync reset, high
  input wire logic in_valid, // write request
  output logic in_ready, // space left
  input wire logic [W-1:0] in_data, // write data
  output logic out_valid, // data present
  input wire logic out_ready, // consumer takes head
  output logic [W-1:0] out_data // head word
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } hdc_fifo_t;

  hdc_fifo_t q, d;
  logic push, pop;

  assign in_ready = (q.cnt != (AW+1)'(D));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_fifo_full;
    in_valid |-> in_ready;
  endproperty
  a_fifo_full: assert property (p_fifo_full) else $error("push into a full fifo");
endmodule

/* File: src/hdc_pins.sv */
/*
  pin level logic of a disk controller: host register port, sector buffer
  control, write stream to the drive.
  assumes host and drive pins are asynchronous; everything runs on clk_sys.
*/
`timescale 1ns/1ps
// What this block does
// [RULE1] buffer select asserted while touching sector buffer
// [RULE2] counter clear pulse before transfers and at end
// [RULE3] fifo buffers leave counter clear unconnected
// [RULE4] interrupt at completion, held until status/command
// [RULE5] read option raises interrupt with data request
// [RULE6] latch enable on size/head/drive register write
// [RULE7] master init clears all but register file
// [RULE8] read strobe host input, device output for buffer
// [RULE9] write strobe host input, released by device otherwise
// [RULE10] host chip select gates every register access
// [RULE11] three select lines pick the register
// [RULE12] shared 8-bit bus driven only during reads
// [RULE13] encoded write stream timed by write clock
// [RULE14] outside retimes stream at twice write clock
// [RULE15] early and late precompensation outputs
// [RULE16] write gate only during data, drops on fault
// [RULE17] write clock is 5 MHz
// [RULE18] step direction high inward, low outward
// [RULE19] buffer request mirrors status bit three
// [RULE20] write fault halts any running command
// [RULE21] drive ready required before drive commands
// [RULE22] async pins synchronised before use
module hdc_pins
  import hdc_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic reset, // sync reset, high
  input wire logic master_init_n, // master init pin, low
  input wire logic cs_n, // host chip select, low
  input wire logic [2:0] reg_sel, // host register select
  input wire logic read_strobe_n_in, // read strobe pin level
  output logic read_strobe_n_out, // read strobe drive value
  output logic read_strobe_oe_n, // read strobe drive enable, low
  input wire logic write_strobe_n_in, // write strobe pin level
  output logic write_strobe_n_out, // write strobe drive value
  output logic write_strobe_oe_n, // write strobe drive enable, low
  input wire logic [7:0] bus_in, // data bus pin level
  output logic [7:0] bus_out, // data bus drive value
  output logic bus_oe_n, // data bus drive enable, low
  output logic buffer_select_out, // sector buffer select
  output logic buffer_counter_clear, // buffer counter clear pulse
  output logic irq_out, // interrupt request
  output logic drive_select_latch_en, // size/head/drive latch
  output logic buffer_request_out, // buffer data request
  input wire logic buffer_full_in, // buffer full or empty
  output logic encoded_write_stream, // mfm write data
  output logic precomp_early, // early precompensation
  output logic precomp_late, // late precompensation
  output logic write_gate, // head write enable
  output logic step_direction, // high moves heads in
  input wire logic write_fault_in, // drive write fault
  input wire logic drive_ready_in // drive ready
);
  import hdc_pkg::*;

  // ==================================================
  // state
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_STEP = 6'h02,
    S_RD_REQ = 6'h04,
    S_WR_REQ = 6'h08,
    S_WR_XFER = 6'h10,
    S_DONE = 6'h20
  } hdc_state_t;

  typedef struct packed {
    logic cs_n;
    logic [2:0] sel;
    logic rd_n;
    logic wr_n;
    logic [7:0] bus;
    logic init_n;
    logic fault;
    logic rdy;
    logic brdy;
  } hdc_pin_t;

  typedef struct packed {
    hdc_pin_t s1;
    hdc_pin_t s2;
    logic rd3;
    logic wr3;
  } hdc_sync_t;

  typedef struct packed {
    hdc_sync_t sy;
    logic [7:0][7:0] tf;
    hdc_state_t st;
    logic [4:0] div;
    logic half;
    logic busy, err, req, irq, irq_opt;
    logic bsel, bclr, rd_drv;
    logic [7:0] bus_out;
    logic bus_oe_n, latch, dir;
    logic [7:0] steps;
    logic [10:0] fetch_left, send_left;
    logic fetch_ph;
    logic [7:0] sh;
    logic [2:0] bit_ix;
    logic enc_on, prev_bit, mfm, early, late, gate;
  } hdc_core_t;

  localparam hdc_core_t CORE_INIT = '{
    sy: '{s1: '1, s2: '1, rd3: 1'b1, wr3: 1'b1},
    tf: {8{TF_RESET}},
    st: S_IDLE,
    div: HALF_LAST,
    bus_oe_n: 1'b1,
    default: '0
  };

  hdc_core_t q, d;
  hdc_pin_t pins;
  logic f_in_valid, f_in_ready, f_out_valid, f_take;
  logic [7:0] f_out_data;
  logic [7:0] status;
  logic f_clr;

  function automatic logic [10:0] sect_bytes(input logic [7:0] size_reg);
    sect_bytes = SECT_MIN << size_reg[SIZE_LSB +: 2];
  endfunction

  assign pins = '{cs_n: cs_n, sel: reg_sel, rd_n: read_strobe_n_in,
                  wr_n: write_strobe_n_in, bus: bus_in, init_n: master_init_n,
                  fault: write_fault_in, rdy: drive_ready_in, brdy: buffer_full_in};

  // ==================================================
  // data fifo between buffer fetch and encoder
  // an aborted transfer leaves bytes behind: flush at done and on master init [RULE7]
  assign f_clr = reset || !q.sy.s2.init_n || q.st == S_DONE;
  hdc_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk_sys(clk_sys),
    .reset(f_clr),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(q.sy.s2.bus),
    .out_valid(f_out_valid),
    .out_ready(f_take),
    .out_data(f_out_data)
  );

  // ==================================================
  // next state
  logic half_tick, wclk_tick, host_on, wr_end, rd_end, clr_irq, cmd_wr;
  logic [7:0] cmd;

  always_comb begin
    d = q;
    f_in_valid = 1'b0;
    f_take = 1'b0;
    d.sy.s1 = pins; // [RULE22]
    d.sy.s2 = q.sy.s1;
    d.sy.rd3 = q.sy.s2.rd_n;
    d.sy.wr3 = q.sy.s2.wr_n;
    half_tick = (q.div == '0);
    wclk_tick = half_tick && q.half; // [RULE17]
    d.div = half_tick ? HALF_LAST : q.div - 5'h01;
    d.half = q.half ^ half_tick;
    status = '0;
    status[ST_BUSY] = q.busy;
    status[ST_RDY] = q.sy.s2.rdy;
    status[ST_FAULT] = q.sy.s2.fault;
    status[ST_REQ] = q.req; // [RULE19]
    status[ST_ERR] = q.err;
    // host strobes count only with chip select and the bus not lent out
    host_on = !q.sy.s2.cs_n && !q.bsel; // [RULE10] [RULE1]
    wr_end = host_on && !q.sy.wr3 && q.sy.s2.wr_n; // [RULE9]
    rd_end = host_on && !q.sy.rd3 && q.sy.s2.rd_n && !q.rd_drv; // [RULE8]
    cmd_wr = wr_end && q.sy.s2.sel == TF_CMD;
    cmd = q.sy.s2.bus;
    clr_irq = cmd_wr || (rd_end && q.sy.s2.sel == TF_CMD); // [RULE4]
    if (host_on && !q.sy.s2.rd_n && !q.rd_drv) begin
      d.bus_oe_n = 1'b0; // [RULE12] [RULE11]
      d.bus_out = (q.sy.s2.sel == TF_CMD) ? status : q.tf[q.sy.s2.sel];
    end else begin
      d.bus_oe_n = 1'b1;
    end
    d.latch = host_on && !q.sy.s2.wr_n && q.sy.s2.sel == TF_SIZE_HEAD; // [RULE6]
    if (wr_end) begin
      d.tf[q.sy.s2.sel] = q.sy.s2.bus;
    end
    if (clr_irq) begin
      d.irq = 1'b0;
    end
    d.bclr = 1'b0;
    // outside master init the stream returns low only on the half-cell grid, never mid cell
    if (half_tick && q.st != S_WR_XFER) begin
      d.mfm = 1'b0; // [RULE13]
    end
    case (q.st)
      S_IDLE: begin
        if (cmd_wr) begin
          d.busy = 1'b1;
          d.err = 1'b0;
          d.bclr = 1'b1; // [RULE2]
          d.irq_opt = cmd[CMD_OPT_BIT];
          if (!q.sy.s2.rdy) begin
            d.err = 1'b1; // [RULE21]
            d.st = S_DONE;
          end else if (cmd[7:4] == CMD_STEP) begin
            d.dir = cmd[CMD_DIR_BIT]; // [RULE18]
            d.steps = q.tf[TF_STEPS];
            d.st = S_STEP;
          end else if (cmd[7:4] == CMD_READ) begin
            d.st = S_RD_REQ;
          end else if (cmd[7:4] == CMD_WRITE) begin
            d.st = S_WR_REQ;
          end else begin
            d.err = 1'b1;
            d.st = S_DONE;
          end
        end
      end
      S_STEP: begin
        if (q.steps == '0) begin
          d.st = S_DONE;
        end else if (wclk_tick) begin
          d.steps = q.steps - 8'h01;
        end
      end
      S_RD_REQ: begin
        d.req = 1'b1;
        if (q.irq_opt && !q.req) begin
          d.irq = 1'b1; // [RULE5]
        end
        if (q.sy.s2.brdy) begin
          d.req = 1'b0;
          d.st = S_DONE;
        end
      end
      S_WR_REQ: begin
        d.req = 1'b1;
        if (q.sy.s2.brdy) begin
          // host has filled the buffer: rewind it and read it back out
          d.req = 1'b0;
          d.bclr = 1'b1; // [RULE2]
          d.bsel = 1'b1;
          d.fetch_left = sect_bytes(q.tf[TF_SIZE_HEAD]);
          d.send_left = sect_bytes(q.tf[TF_SIZE_HEAD]);
          // a faulted transfer may have stopped mid byte
          d.bit_ix = '0;
          d.prev_bit = 1'b0;
          d.fetch_ph = 1'b0;
          d.enc_on = 1'b0;
          d.st = S_WR_XFER;
        end
      end
      S_WR_XFER: begin
        // fetch: strobe low for one write clock, sample, push
        if (wclk_tick) begin
          if (q.fetch_ph) begin
            f_in_valid = 1'b1;
            d.rd_drv = 1'b0;
            d.fetch_ph = 1'b0;
            d.fetch_left = q.fetch_left - 11'h001;
          end else if (q.fetch_left != '0 && f_in_ready) begin
            d.rd_drv = 1'b1; // [RULE1] [RULE8]
            d.fetch_ph = 1'b1;
          end
        end
        // encoder: clock half-cell then data half-cell per bit
        if (half_tick) begin
          if (!q.enc_on) begin
            // start only once the fifo is full or every byte is fetched, so fetch stays ahead
            if (!q.half && f_out_valid && (!f_in_ready || q.fetch_left == '0)) begin
              f_take = 1'b1;
              d.sh = f_out_data;
              d.send_left = q.send_left - 11'h001;
              d.enc_on = 1'b1;
              d.gate = 1'b1; // [RULE16]
            end
          end else if (!q.half) begin
            d.mfm = !q.prev_bit && !q.sh[7]; // [RULE13]
            d.early = 1'b0;
            d.late = 1'b0;
          end else begin
            d.mfm = q.sh[7];
            d.early = q.sh[7] && !q.prev_bit && q.sh[6]; // [RULE15]
            d.late = q.sh[7] && q.prev_bit && !q.sh[6];
            d.prev_bit = q.sh[7];
            d.sh = {q.sh[6:0], 1'b0};
            d.bit_ix = q.bit_ix + 3'h1;
            if (q.bit_ix == 3'h7) begin
              if (q.send_left == '0) begin
                d.gate = 1'b0;
                d.enc_on = 1'b0;
                d.bsel = 1'b0;
                d.st = S_DONE;
              end else if (f_out_valid) begin
                f_take = 1'b1;
                d.sh = f_out_data;
                d.send_left = q.send_left - 11'h001;
              end else begin
                d.err = 1'b1;
                d.gate = 1'b0;
                d.bsel = 1'b0;
                d.st = S_DONE;
              end
            end
          end
        end
      end
      S_DONE: begin
        d.busy = 1'b0;
        d.req = 1'b0;
        d.bclr = 1'b1; // [RULE2]
        d.irq = 1'b1; // [RULE4]
        d.st = S_IDLE;
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
    // a fault stops the command and the head current in the next cycle
    if (q.sy.s2.fault && q.busy && q.st != S_DONE) begin
      d.gate = 1'b0; // [RULE16] [RULE20]
      d.rd_drv = 1'b0;
      d.bsel = 1'b0;
      d.req = 1'b0;
      d.err = 1'b1;
      d.st = S_DONE;
    end
    // master init: everything but the register file and the synchronisers
    if (!q.sy.s2.init_n) begin
      d = CORE_INIT; // [RULE7]
      d.tf = q.tf;
      d.sy.s1 = pins;
      d.sy.s2 = q.sy.s1;
      d.sy.rd3 = q.sy.s2.rd_n;
      d.sy.wr3 = q.sy.s2.wr_n;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q <= CORE_INIT;
    end else begin
      q <= d;
    end
  end

  // ==================================================
  // outputs
  assign read_strobe_n_out = !q.rd_drv;
  assign read_strobe_oe_n = !q.rd_drv;
  // buffer writes never happen here, so the write strobe stays released
  assign write_strobe_n_out = 1'b1; // [RULE9]
  assign write_strobe_oe_n = 1'b1;
  assign bus_out = q.bus_out;
  assign bus_oe_n = q.bus_oe_n;
  assign buffer_select_out = q.bsel;
  assign buffer_counter_clear = q.bclr; // [RULE3]
  assign irq_out = q.irq;
  assign drive_select_latch_en = q.latch;
  assign buffer_request_out = q.req; // [RULE19]
  assign encoded_write_stream = q.mfm; // [RULE13]
  assign precomp_early = q.early;
  assign precomp_late = q.late;
  assign write_gate = q.gate;
  assign step_direction = q.dir;

  // ==================================================
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_cmd_start;
    q.st == S_IDLE && cmd_wr && q.sy.s2.init_n && !(q.sy.s2.fault && q.busy);
  endsequence
  property p_bsel;
    q.rd_drv |-> q.bsel;
  endproperty
  a_bsel: assert property (p_bsel) else $error("buffer strobe without select"); // [RULE1]
  property p_clr;
    s_cmd_start |=> q.bclr && q.busy;
  endproperty
  a_clr: assert property (p_clr) else $error("no counter clear at start"); // [RULE2]
  property p_irq_done;
    q.st == S_DONE && q.sy.s2.init_n |=> q.irq ##1 (q.st == S_IDLE || !q.irq);
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("no irq at completion"); // [RULE4]
  property p_irq_hold;
    q.irq && !clr_irq && q.sy.s2.init_n |=> q.irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early"); // [RULE4]
  property p_opt;
    q.st == S_RD_REQ && q.irq_opt && !q.req && q.sy.s2.init_n && !q.sy.s2.fault |=> q.irq;
  endproperty
  a_opt: assert property (p_opt) else $error("irq missing with request"); // [RULE5]
  property p_latch;
    host_on && !q.sy.s2.wr_n && q.sy.s2.sel == TF_SIZE_HEAD && q.sy.s2.init_n |=> q.latch;
  endproperty
  a_latch: assert property (p_latch) else $error("latch enable missing"); // [RULE6]
  property p_mr;
    !q.sy.s2.init_n |=> q.st == S_IDLE && !q.irq && q.tf == $past(q.tf);
  endproperty
  a_mr: assert property (p_mr) else $error("master init wrong"); // [RULE7]
  property p_bus_own;
    !read_strobe_oe_n |-> bus_oe_n;
  endproperty
  a_bus_own: assert property (p_bus_own) else $error("bus driven on buffer read"); // [RULE12]
  property p_fault_gate;
    q.sy.s2.fault |=> !write_gate;
  endproperty
  a_fault_gate: assert property (p_fault_gate) else $error("write gate held on fault"); // [RULE16]
  property p_halt;
    q.sy.s2.fault && q.busy && q.st != S_DONE && q.sy.s2.init_n
      |=> q.st == S_DONE ##1 !q.busy;
  endproperty
  a_halt: assert property (p_halt) else $error("fault did not halt"); // [RULE20]
  property p_wd_rate;
    !half_tick && q.sy.s2.init_n |=> $stable(encoded_write_stream);
  endproperty
  a_wd_rate: assert property (p_wd_rate) else $error("stream off cell grid"); // [RULE13]
  property p_dir;
    q.st == S_STEP && d.st == S_STEP |=> $stable(step_direction);
  endproperty
  a_dir: assert property (p_dir) else $error("direction moved while stepping"); // [RULE18]
endmodule

/* File: dv/hdc_buf_model.sv */
/*
  sector buffer model, fifo flavour: answers device read strobes with bytes.
  assumes the bench resolves the shared bus and strobe wires from all enables.
*/
`timescale 1ns/1ps
module hdc_buf_model (
  input wire logic clk_sys, // system clock
  input wire logic buffer_select_out, // buffer select from device
  input wire logic read_strobe_n_out, // device read strobe value
  input wire logic read_strobe_oe_n, // device strobe enable, low
  output logic [7:0] buf_data, // byte offered on the bus
  output logic buf_en, // model drives the bus
  output int rd_count = 0, // buffer reads seen
  output int bad_count = 0 // reads without buffer select
);
  // ==================================================
  // strobe response
  // a fifo has no address counter, so the counter clear pin stays unwired
  logic rd_q = 1'b0;
  logic rd_now;
  assign rd_now = !read_strobe_oe_n && !read_strobe_n_out;
  // drive only while selected and strobed, released otherwise
  assign buf_en = rd_now && buffer_select_out;
  assign buf_data = 8'(rd_count) ^ 8'h5a;
  // sample away from the edge that launches the device's strobe
  always @(negedge clk_sys) begin
    rd_q <= rd_now;
    if (rd_now && !rd_q) begin
      rd_count <= rd_count + 1;
      if (!buffer_select_out) begin
        bad_count <= bad_count + 1;
      end
    end
  end
endmodule

/* File: dv/tb.sv */
/*
  self-checking bench for the disk controller pin logic.
  assumes hdc_pins and its fifo are compiled with hdc_pkg; one 200 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  import hdc_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic master_init_n = 1'b1;
  logic cs_n = 1'b1;
  logic [2:0] reg_sel = 3'h0;
  logic host_rd_n = 1'b1;
  logic host_wr_n = 1'b1;
  logic [7:0] host_d = 8'h00;
  logic host_en = 1'b0;
  logic buffer_full_in = 1'b0;
  logic write_fault_in = 1'b0;
  logic drive_ready_in = 1'b1;
  logic read_strobe_n_out, read_strobe_oe_n, write_strobe_n_out, write_strobe_oe_n;
  logic [7:0] bus_out, buf_data, bus_lvl, last_q = 8'h00;
  logic bus_oe_n, buffer_select_out, buffer_counter_clear, irq_out;
  logic drive_select_latch_en, buffer_request_out, encoded_write_stream;
  logic precomp_early, precomp_late, write_gate, step_direction, buf_en;
  logic rd_lvl, wr_lvl, ws_q = 1'b0;
  logic early_seen = 1'b0;
  logic late_seen = 1'b0;
  int rd_count, bad_count, num_errors = 0, cmp_count = 0;
  int clr_cnt = 0, cyc = 0, last_edge = -100, edges = 0;
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ==================================================
  // wire resolution: released bus shows inverse of last level
  assign bus_lvl = !bus_oe_n ? bus_out : host_en ? host_d : buf_en ? buf_data : ~last_q;
  assign rd_lvl = !read_strobe_oe_n ? read_strobe_n_out : host_rd_n;
  assign wr_lvl = !write_strobe_oe_n ? write_strobe_n_out : host_wr_n;
  hdc_pins dut (.clk_sys, .reset, .master_init_n, .cs_n, .reg_sel,
    .read_strobe_n_in(rd_lvl), .read_strobe_n_out, .read_strobe_oe_n,
    .write_strobe_n_in(wr_lvl), .write_strobe_n_out, .write_strobe_oe_n,
    .bus_in(bus_lvl), .bus_out, .bus_oe_n, .buffer_select_out, .buffer_counter_clear,
    .irq_out, .drive_select_latch_en, .buffer_request_out, .buffer_full_in,
    .encoded_write_stream, .precomp_early, .precomp_late, .write_gate,
    .step_direction, .write_fault_in, .drive_ready_in);
  hdc_buf_model buf_m (.clk_sys, .buffer_select_out, .read_strobe_n_out,
    .read_strobe_oe_n, .buf_data, .buf_en, .rd_count, .bad_count);
  // ==================================================
  // monitors
  // watch on the falling edge so flop outputs have settled
  always @(negedge clk_sys) begin
    last_q <= bus_lvl;
    cyc <= cyc + 1;
    ws_q <= encoded_write_stream;
    if (buffer_counter_clear === 1'b1) clr_cnt <= clr_cnt + 1;
    if (precomp_early === 1'b1) early_seen <= 1'b1;
    if (precomp_late === 1'b1) late_seen <= 1'b1;
    if (precomp_early === 1'b1 && precomp_late === 1'b1) begin
      num_errors++;
      $display("[ERR] %0t early and late together", $time);
    end
    if (encoded_write_stream !== ws_q) begin
      edges <= edges + 1;
      last_edge <= cyc;
      if (cyc - last_edge < 20) begin
        num_errors++;
        $display("[ERR] %0t write stream changed inside a half cell", $time);
      end
    end
  end
  // ==================================================
  // helpers
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_on(input int w, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if ((w == 0 && irq_out === 1'b1) || (w == 1 && write_gate === 1'b1) ||
          (w == 2 && buffer_request_out === 1'b1) ||
          (w == 3 && buffer_select_out === 1'b1) ||
          (w == 4 && buffer_request_out === 1'b0)) break;
      tick(1);
    end
    if (i == lim) begin
      num_errors++;
      $display("[ERR] %0t wait %0d timed out", $time, w);
      give_verdict();
    end
  endtask
  task automatic host_wr(input logic [2:0] a, input logic [7:0] d, input logic sel_n);
    cs_n = sel_n;
    reg_sel = a;
    host_d = d;
    host_en = 1'b1;
    host_wr_n = 1'b0;
    tick(6);
    host_wr_n = 1'b1;
    tick(6);
    cs_n = 1'b1;
    host_en = 1'b0;
    tick(2);
  endtask
  task automatic host_rd(input logic [2:0] a, output logic [7:0] d);
    cs_n = 1'b0;
    reg_sel = a;
    host_rd_n = 1'b0;
    tick(6);
    chk({7'h0, bus_oe_n}, 8'h00, "bus not driven on read");
    d = bus_lvl;
    host_rd_n = 1'b1;
    tick(6);
    cs_n = 1'b1;
    tick(2);
  endtask
  // ==================================================
  // scenarios
  task automatic t_reset();
    chk({bus_oe_n, read_strobe_oe_n, write_strobe_oe_n, read_strobe_n_out, write_strobe_n_out},
      8'h1f, "pins released");
    chk({irq_out, write_gate, buffer_select_out}, 8'h00, "outputs after reset");
    $display("test reset done");
  endtask
  task automatic t_regs();
    logic [7:0] d;
    host_wr(3'h2, 8'ha5, 1'b0);
    host_wr(3'h3, 8'hc3, 1'b0);
    host_wr(3'h3, 8'h11, 1'b1);
    host_rd(3'h2, d);
    chk(d, 8'ha5, "register 2 readback");
    host_rd(3'h3, d);
    chk(d, 8'hc3, "write without select taken");
    chk({7'h0, write_strobe_oe_n}, 8'h01, "write strobe driven");
    $display("test regs done");
  endtask
  task automatic t_latch();
    cs_n = 1'b0;
    reg_sel = TF_SIZE_HEAD;
    host_d = 8'h00;
    host_en = 1'b1;
    host_wr_n = 1'b0;
    tick(6);
    chk({7'h0, drive_select_latch_en}, 8'h01, "latch enable low");
    host_wr_n = 1'b1;
    tick(6);
    cs_n = 1'b1;
    host_en = 1'b0;
    chk({7'h0, drive_select_latch_en}, 8'h00, "latch enable stuck");
    tick(2);
    $display("test latch done");
  endtask
  task automatic t_step(input logic dir);
    logic [7:0] s;
    int c0;
    host_wr(TF_STEPS, 8'h02, 1'b0);
    c0 = clr_cnt;
    host_wr(TF_CMD, {CMD_STEP, 3'h0, dir}, 1'b0);
    wait_on(0, 2000);
    tick(1);
    chk({7'h0, step_direction}, {7'h0, dir}, "step direction");
    chk(8'(clr_cnt - c0), 8'h02, "clear pulses for step");
    tick(20);
    chk({7'h0, irq_out}, 8'h01, "irq not held");
    host_rd(TF_CMD, s);
    chk({6'h0, s[ST_BUSY], irq_out}, 8'h00, "irq after status read");
    $display("test step done");
  endtask
  task automatic t_read(input logic opt);
    logic [7:0] s;
    host_wr(TF_CMD, {CMD_READ, opt, 3'h0}, 1'b0);
    wait_on(2, 200);
    tick(3);
    chk({7'h0, irq_out}, {7'h0, opt}, "irq with request");
    if (!opt) begin
      host_rd(TF_CMD, s);
      chk({7'h0, s[ST_REQ]}, 8'h01, "status request bit");
    end
    buffer_full_in = 1'b1;
    wait_on(4, 200);
    tick(3);
    buffer_full_in = 1'b0;
    chk({7'h0, irq_out}, 8'h01, "irq at completion");
    host_rd(TF_CMD, s);
    chk({7'h0, s[ST_REQ]}, 8'h00, "request bit left set");
    $display("test read done");
  endtask
  task automatic t_write();
    logic [7:0] s;
    int c0, n0;
    host_wr(TF_SIZE_HEAD, 8'h00, 1'b0);
    n0 = rd_count;
    c0 = clr_cnt;
    host_wr(TF_CMD, {CMD_WRITE, 4'h0}, 1'b0);
    wait_on(2, 200);
    buffer_full_in = 1'b1;
    wait_on(3, 200);
    buffer_full_in = 1'b0;
    tick(1);
    chk(8'(clr_cnt - c0), 8'h02, "clear before transfer");
    wait_on(1, 20000);
    wait_on(0, 50000);
    tick(1);
    chk(8'(rd_count - n0), 8'h80, "sector bytes read");
    chk(8'(bad_count), 8'h00, "read without select");
    chk(8'(clr_cnt - c0), 8'h03, "clear at completion");
    chk({write_gate, buffer_select_out}, 8'h00, "gate or select left on");
    chk({early_seen, late_seen}, 8'h03, "precomp never used");
    chk({7'h0, edges > 0}, 8'h01, "write stream idle");
    host_rd(TF_CMD, s);
    $display("test write done");
  endtask
  task automatic t_fault();
    logic [7:0] s;
    host_wr(TF_CMD, {CMD_WRITE, 4'h0}, 1'b0);
    wait_on(2, 200);
    buffer_full_in = 1'b1;
    wait_on(1, 20000);
    buffer_full_in = 1'b0;
    write_fault_in = 1'b1;
    tick(4);
    chk({7'h0, write_gate}, 8'h00, "gate kept on fault");
    wait_on(0, 50);
    write_fault_in = 1'b0;
    host_rd(TF_CMD, s);
    chk({7'h0, s[ST_ERR]}, 8'h01, "fault did not halt");
    $display("test fault done");
  endtask
  task automatic t_init();
    logic [7:0] d;
    host_wr(3'h2, 8'h3c, 1'b0);
    host_wr(TF_CMD, {CMD_READ, 4'h8}, 1'b0);
    wait_on(2, 200);
    master_init_n = 1'b0;
    tick(4);
    master_init_n = 1'b1;
    tick(2);
    chk({buffer_request_out, irq_out}, 8'h00, "state kept by init");
    host_rd(3'h2, d);
    chk(d, 8'h3c, "register lost by init");
    $display("test init done");
  endtask
  task automatic t_notready();
    logic [7:0] s;
    drive_ready_in = 1'b0;
    host_wr(TF_CMD, {CMD_READ, 4'h0}, 1'b0);
    wait_on(0, 200);
    host_rd(TF_CMD, s);
    chk({s[ST_RDY], s[ST_ERR]}, 8'h01, "command ran without ready");
    drive_ready_in = 1'b1;
    $display("test notready done");
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    tick(2);
    t_reset();
    t_regs();
    t_latch();
    t_step(1'b1);
    t_step(1'b0);
    t_read(1'b0);
    t_read(1'b1);
    t_write();
    t_fault();
    t_init();
    t_notready();
    give_verdict();
  end
endmodule
